// File: ahb_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_defines.svh"

module ahb_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire irq_route_pkg::htrans_type htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire irq_route_pkg::word_type rdata,
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [11:0] rd_addr,
  output logic hreadyout,
  output logic hresp,
  output irq_route_pkg::word_type hrdata
);
  import irq_route_pkg::*;

  typedef struct packed {
    logic wpend;
    logic [11:0] waddr;
  } st_type;
  st_type st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wpend = 1'b0;
    if (hsel && hready && htrans == `HTRANS_NONSEQ && hwrite) begin
      nxt_st.wpend = 1'b1;
      nxt_st.waddr = haddr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero wait states; read address is taken straight from haddr, only the write address is captured
  assign wr_en = st_ff.wpend;
  assign wr_addr = st_ff.waddr;
  assign rd_addr = haddr;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata;
  logic unused_ok;
  assign unused_ok = ^hsize;
endmodule

`default_nettype wire

// File: far_side.sv
`timescale 1ns/1ps
`default_nettype none
module far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic fire,
  input wire logic [3:0] fire_src,
  input wire logic zero,
  input wire logic [3:0] dma_request,
  input wire logic dtc_request,
  input wire logic [3:0] dtc_request_src,
  output logic [15:0] src_event,
  output logic [3:0] dma_done,
  output logic dtc_done,
  output logic [3:0] dtc_done_src,
  output logic dtc_count_zero
);
  // hold stalls both engines, so a slow consumer leaves requests standing
  always_ff @(posedge clk) begin
    if (rst) begin
      src_event <= 16'h0000;
      dma_done <= 4'h0;
      dtc_done <= 1'b0;
      dtc_done_src <= 4'h0;
      dtc_count_zero <= 1'b0;
    end else begin
      src_event <= fire ? 16'h0001 << fire_src : 16'h0000;
      dma_done <= hold ? 4'h0 : dma_request & ~dma_done;
      dtc_done <= !hold && dtc_request && !dtc_done;
      dtc_done_src <= dtc_request_src;
      dtc_count_zero <= zero;
    end
  end
endmodule
`default_nettype wire

// File: interrupt_source_routing.sv
// Overview of operation
// - each dma channel selects its own source
// - trigger 10, enable, ack gives dma ownership
// - unowned source to dtc if enabled, else cpu
// - cpu-select transfer clears enable, raises cpu request
// - counter zero clears enable, raises cpu request
// - priority-set enable uses per-source level
// - dtc transfer precedes cpu exception handling
// - dma and other consumers act independently
// - ack set: dma uses and clears flag
// - clear control follows ack, enable, cpu-select
// - serial/adc flags clear on engine register access; here only for a dma-owned source or one enabled without cpu-select
// - lowest channel only clears shared request
// - disabled channel gives source to cpu/dtc
// - dma ignores interrupt priority settings
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_defines.svh"

module interrupt_source_routing #(
  parameter int NUM_SRC = 16,
  parameter int NUM_CH = 4,
  parameter int SEL_W = 4,
  parameter int LVL_W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire irq_route_pkg::htrans_type htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire irq_route_pkg::word_type hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output irq_route_pkg::word_type hrdata,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] src_special,
  input wire logic [NUM_CH-1:0] dma_done,
  input wire logic dtc_done,
  input wire logic [SEL_W-1:0] dtc_done_src,
  input wire logic dtc_count_zero,
  input wire logic [NUM_SRC-1:0] engine_reg_access,
  output logic [NUM_SRC-1:0] src_flag,
  output logic [NUM_CH-1:0] dma_request,
  output logic dtc_request,
  output logic [SEL_W-1:0] dtc_request_src,
  output logic cpu_request,
  output logic [SEL_W-1:0] cpu_request_src,
  output logic [LVL_W-1:0] cpu_request_level
);
  import irq_route_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // whole block state; flag, request and read-data outputs are read straight from these flops
  typedef struct packed {
    // flags and per-source routing bits
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] xfer_en;
    logic [NUM_SRC-1:0] cpu_sel;
    logic [NUM_SRC-1:0] cpu_extra;
    // channel words, source levels, cpu priority
    logic [NUM_CH-1:0][15:0] ch_ctrl;
    logic [NUM_SRC-1:0][LVL_W-1:0] lvl;
    logic prio_set_en;
    logic [LVL_W-1:0] cpu_prio;
    // registered requests and read word
    logic [NUM_CH-1:0] dma_req;
    logic dtc_req;
    logic [SEL_W-1:0] dtc_src;
    logic cpu_req;
    logic [SEL_W-1:0] cpu_src;
    logic [LVL_W-1:0] cpu_lvl;
    word_type rdata;
  } st_type;
  st_type st_ff, nxt_st;

  ////////////////////////////////////////////////////////////////////
  logic wr_en;
  logic [11:0] wr_addr;
  logic [11:0] rd_addr;
  word_type bus_rdata;

  // zero-wait slave: the read word is flopped here, not in the bus shim
  ahb_regs u_bus (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rdata(bus_rdata),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .rd_addr(rd_addr),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
  );

  ////////////////////////////////////////////////////////////////////
  logic [NUM_CH*SEL_W-1:0] ch_select;
  logic [NUM_CH-1:0] ch_exclusive;
  logic [NUM_CH-1:0] ch_armed;
  logic [NUM_SRC-1:0] dma_owned;
  logic [NUM_CH-1:0] ch_request;
  logic [NUM_SRC-1:0] dtc_route;
  logic [NUM_SRC-1:0] cpu_route;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      assign ch_select[c*SEL_W +: SEL_W] = st_ff.ch_ctrl[c][`CH_SEL_LSB +: SEL_W];
      // trigger high=1, low=0 is the interrupt-driven mode
      assign ch_armed[c] = st_ff.ch_ctrl[c][`CH_ENABLE_BIT] &&
        st_ff.ch_ctrl[c][`CH_TRIG_HIGH_BIT] && !st_ff.ch_ctrl[c][`CH_TRIG_LOW_BIT];
      assign ch_exclusive[c] = ch_armed[c] && st_ff.ch_ctrl[c][`CH_ACK_BIT];
    end
  endgenerate

  // ownership and routing stay pure logic; only results are flopped
  source_router #(
    .NUM_SRC(NUM_SRC),
    .NUM_CH(NUM_CH),
    .SEL_W(SEL_W)
  ) u_router (
    .src_pending(st_ff.pend),
    .ch_select(ch_select),
    .ch_exclusive(ch_exclusive),
    .ch_armed(ch_armed),
    .transfer_source_enable(st_ff.xfer_en),
    .cpu_interrupt_select(st_ff.cpu_sel),
    .dma_owned(dma_owned),
    .ch_request(ch_request),
    .dtc_route(dtc_route),
    .cpu_route(cpu_route)
  );

  ////////////////////////////////////////////////////////////////////
  logic [NUM_SRC-1:0] cpu_want;
  logic [NUM_SRC-1:0] dtc_busy_src;
  logic [NUM_SRC-1:0] wr_clear;
  logic [NUM_SRC-1:0] dma_clear;

  always_comb begin
    wr_clear = '0;
    if (wr_en && wr_addr == `ADDR_FLAG_CLEAR) begin
      wr_clear = hwdata[NUM_SRC-1:0];
    end

    dma_clear = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      // only the winning (lowest index) channel clears; no request is held
      if (dma_done[i] && st_ff.ch_ctrl[i][`CH_ACK_BIT] &&
          !(|(dma_done & ((NUM_CH)'(1) << i) - (NUM_CH)'(1)))) begin
        dma_clear[ch_select[i*SEL_W +: SEL_W]] = 1'b1;
      end
    end

    // dtc-first: the dtc is asked while the enable bit stands; the cpu
    // is offered the source only once the dtc has dropped that bit
    dtc_busy_src = dtc_route;
    cpu_want = (cpu_route & ~dtc_route) | st_ff.cpu_extra;
  end

  ////////////////////////////////////////////////////////////////////
  // next state: flags, enables, bus writes, then registered outputs
  always_comb begin
    logic [LVL_W-1:0] best;
    logic found;
    nxt_st = st_ff;
    best = '0;
    found = 1'b0;

    // set wins over clear
    nxt_st.pend = (st_ff.pend & ~wr_clear & ~dma_clear) | src_event;
    if (dtc_done && st_ff.xfer_en[dtc_done_src] && !st_ff.cpu_sel[dtc_done_src] &&
        !src_event[dtc_done_src]) begin
      nxt_st.pend[dtc_done_src] = 1'b0;
    end

    for (int i = 0; i < NUM_SRC; i++) begin
      // serial/adc flags clear when the owning engine touches their register
      if (src_special[i] && engine_reg_access[i] && !src_event[i] &&
          (dma_owned[i] || (st_ff.xfer_en[i] && !st_ff.cpu_sel[i]))) begin
        nxt_st.pend[i] = 1'b0;
      end
    end

    // clear first so a completion in the same cycle as a flag write is kept
    nxt_st.cpu_extra = st_ff.cpu_extra & ~wr_clear & ~dma_owned;
    // the latched cpu request outlives the enable bit it cleared
    if (dtc_done && st_ff.xfer_en[dtc_done_src] &&
        (st_ff.cpu_sel[dtc_done_src] || dtc_count_zero)) begin
      nxt_st.xfer_en[dtc_done_src] = 1'b0;
      nxt_st.cpu_extra[dtc_done_src] = 1'b1;
    end

    // bus writes commit in the data phase, one cycle after the address
    if (wr_en) begin
      unique case (wr_addr)
        `ADDR_XFER_ENABLE: nxt_st.xfer_en = hwdata[NUM_SRC-1:0];
        `ADDR_CPU_SELECT: nxt_st.cpu_sel = hwdata[NUM_SRC-1:0];
        `ADDR_PRIO_CTRL: begin
          nxt_st.prio_set_en = hwdata[`PRIO_SET_ENABLE_BIT];
          nxt_st.cpu_prio = hwdata[`CPU_PRIO_LSB +: LVL_W];
        end
        default: begin
          // channel words and levels decode by index
          for (int k = 0; k < NUM_CH; k++) begin
            if (wr_addr == `ADDR_CH_BASE + 12'(k << `ADDR_WORD_LSB)) begin
              nxt_st.ch_ctrl[k] = hwdata[15:0];
            end
          end
          for (int k = 0; k < NUM_SRC; k++) begin
            if (wr_addr == `ADDR_LVL_BASE + 12'(k << `ADDR_WORD_LSB)) begin
              nxt_st.lvl[k] = hwdata[LVL_W-1:0];
            end
          end
        end
      endcase
    end

    // dma sees raw requests, no priority involved
    nxt_st.dma_req = ch_request;
    nxt_st.dtc_req = |dtc_busy_src;

    // lowest index wins; the rest wait for a later slot
    nxt_st.dtc_src = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (dtc_busy_src[i]) begin
        nxt_st.dtc_src = SEL_W'(i);
      end
    end

    // ranking covers only cpu requests; the engines never enter it
    nxt_st.cpu_src = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // level when priority-set enabled, else lowest index wins
      if (cpu_want[i] && (!found ||
          (st_ff.prio_set_en && st_ff.lvl[i] > best))) begin
        found = 1'b1;
        best = st_ff.prio_set_en ? st_ff.lvl[i] : st_ff.cpu_prio;
        nxt_st.cpu_src = SEL_W'(i);
      end
    end
    nxt_st.cpu_req = found;
    nxt_st.cpu_lvl = best;

    // read word taken a cycle early so hrdata leaves a flop
    unique case (rd_addr)
      `ADDR_XFER_ENABLE: nxt_st.rdata = word_type'(st_ff.xfer_en);
      `ADDR_CPU_SELECT: nxt_st.rdata = word_type'(st_ff.cpu_sel);
      `ADDR_PRIO_CTRL: nxt_st.rdata = word_type'({st_ff.prio_set_en, st_ff.cpu_prio});
      `ADDR_PENDING: nxt_st.rdata = word_type'(st_ff.pend);
      `ADDR_CPU_REQ: nxt_st.rdata = word_type'(cpu_want);
      `ADDR_DTC_REQ: nxt_st.rdata = word_type'(dtc_route);
      default: begin
        nxt_st.rdata = `RESET_WORD;
        // unmapped offsets read as zero
        for (int k = 0; k < NUM_CH; k++) begin
          if (rd_addr == `ADDR_CH_BASE + 12'(k << `ADDR_WORD_LSB)) begin
            nxt_st.rdata = word_type'(st_ff.ch_ctrl[k]);
          end
        end
        for (int k = 0; k < NUM_SRC; k++) begin
          if (rd_addr == `ADDR_LVL_BASE + 12'(k << `ADDR_WORD_LSB)) begin
            nxt_st.rdata = word_type'(st_ff.lvl[k]);
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign bus_rdata = st_ff.rdata;
  assign src_flag = st_ff.pend;
  assign dma_request = st_ff.dma_req;
  assign dtc_request = st_ff.dtc_req;
  assign dtc_request_src = st_ff.dtc_src;
  assign cpu_request = st_ff.cpu_req;
  assign cpu_request_src = st_ff.cpu_src;
  assign cpu_request_level = st_ff.cpu_lvl;
endmodule

`default_nettype wire

// File: irq_route_defines.svh
`ifndef IRQ_ROUTE_DEFINES_SVH
`define IRQ_ROUTE_DEFINES_SVH

// register byte addresses
`define ADDR_XFER_ENABLE 12'h000
`define ADDR_CPU_SELECT 12'h004
`define ADDR_PRIO_CTRL 12'h008
`define ADDR_PENDING 12'h00C
`define ADDR_CPU_REQ 12'h010
`define ADDR_DTC_REQ 12'h014
`define ADDR_FLAG_CLEAR 12'h018
`define ADDR_CH_BASE 12'h040
`define ADDR_LVL_BASE 12'h080

// dma channel control word fields
`define CH_SEL_LSB 0
`define CH_ENABLE_BIT 8
`define CH_TRIG_LOW_BIT 9
`define CH_TRIG_HIGH_BIT 10
`define CH_ACK_BIT 11
`define CH_PRIO_LSB 12

// priority control fields
`define PRIO_SET_ENABLE_BIT 3
`define CPU_PRIO_LSB 0

`define RESET_WORD 32'h0000_0000
`define HTRANS_NONSEQ 2'h2
`define ADDR_WORD_LSB 2

`endif

// File: irq_route_pkg.sv
package irq_route_pkg;
  typedef logic [1:0] htrans_type;
  typedef logic [31:0] word_type;
  typedef enum logic [1:0] {
    OWNER_CPU,
    OWNER_DTC,
    OWNER_DTC_CPU,
    OWNER_DMA
  } owner_type;
endpackage

// File: route_chk.sv
`timescale 1ns/1ps
`default_nettype none
module route_chk #(
  parameter int NUM_SRC = 16,
  parameter int NUM_CH = 4,
  parameter int SEL_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire irq_route_pkg::htrans_type htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] src_special,
  input wire logic [NUM_CH-1:0] dma_done,
  input wire logic dtc_done,
  input wire logic [NUM_SRC-1:0] engine_reg_access,
  input wire logic [NUM_SRC-1:0] src_flag,
  input wire logic [NUM_CH-1:0] dma_request,
  input wire logic dtc_request,
  input wire logic [SEL_W-1:0] dtc_request_src,
  input wire logic cpu_request
);
  import irq_route_pkg::*;
  logic [NUM_SRC-1:0] flag_ff, acc_now;
  logic wr_ff, done_ff, done2_ff, quiet;
  // a flag write lands one cycle after its address phase
  assign acc_now = engine_reg_access & src_special & ~src_event;
  assign quiet = src_event == '0 && dma_done == '0 && !dtc_done && engine_reg_access == '0
    && !wr_ff;
  always_ff @(posedge clk) begin
    flag_ff <= src_flag;
    wr_ff <= hsel && hready && htrans == 2'h2 && hwrite;
    done_ff <= dtc_done;
    done2_ff <= done_ff;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_event_sets: assert property (
    src_event != '0 |=> (src_flag & $past(src_event)) == $past(src_event))
    else $error("event did not set flag");
  a_flag_holds: assert property (quiet |=> src_flag == $past(src_flag))
    else $error("flag changed without cause");
  // only where the dtc owns clearing and no write or completion moved the bits
  a_special_clear: assert property (
    dtc_request && acc_now[dtc_request_src] && !done_ff && !$past(wr_ff)
    |=> !src_flag[$past(dtc_request_src)])
    else $error("engine access left flag set");
  a_dtc_from_flag: assert property (
    dtc_request |-> flag_ff[dtc_request_src] || src_flag[dtc_request_src])
    else $error("transfer request without flag");
  a_dma_from_flag: assert property (dma_request != '0 |-> (flag_ff | src_flag) != '0)
    else $error("channel request without flag");
  a_cpu_cause: assert property (
    $rose(cpu_request) |-> (flag_ff | src_flag) != '0 || done_ff || done2_ff)
    else $error("cpu request without cause");
  cover property (dma_request != '0);
  cover property (dtc_request && cpu_request);
  cover property (cpu_request && src_flag == '0);
endmodule
bind interrupt_source_routing route_chk #(.NUM_SRC(NUM_SRC), .NUM_CH(NUM_CH),
  .SEL_W(SEL_W)) chk_i (.clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .src_event(src_event), .src_special(src_special), .dma_done(dma_done),
  .dtc_done(dtc_done), .engine_reg_access(engine_reg_access), .src_flag(src_flag),
  .dma_request(dma_request), .dtc_request(dtc_request),
  .dtc_request_src(dtc_request_src), .cpu_request(cpu_request));
`default_nettype wire

// File: source_router.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_defines.svh"

module source_router #(
  parameter int NUM_SRC = 16,
  parameter int NUM_CH = 4,
  parameter int SEL_W = 4
) (
  input wire logic [NUM_SRC-1:0] src_pending,
  input wire logic [NUM_CH*SEL_W-1:0] ch_select,
  input wire logic [NUM_CH-1:0] ch_exclusive,
  input wire logic [NUM_CH-1:0] ch_armed,
  input wire logic [NUM_SRC-1:0] transfer_source_enable,
  input wire logic [NUM_SRC-1:0] cpu_interrupt_select,
  output logic [NUM_SRC-1:0] dma_owned,
  output logic [NUM_CH-1:0] ch_request,
  output logic [NUM_SRC-1:0] dtc_route,
  output logic [NUM_SRC-1:0] cpu_route
);
  import irq_route_pkg::*;

  logic [NUM_CH-1:0] hit [NUM_SRC];

  genvar s, c;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : g_src
      for (c = 0; c < NUM_CH; c++) begin : g_ch
        // selection mux per channel, independent of interrupt priority
        assign hit[s][c] = ch_exclusive[c] &&
          (ch_select[c*SEL_W +: SEL_W] == SEL_W'(s));
      end
      assign dma_owned[s] = |hit[s];
      // plain routing so a setting change acts next cycle
      assign dtc_route[s] = src_pending[s] && !dma_owned[s] &&
        transfer_source_enable[s];
      assign cpu_route[s] = src_pending[s] && !dma_owned[s] &&
        (!transfer_source_enable[s] || cpu_interrupt_select[s]);
    end
    for (c = 0; c < NUM_CH; c++) begin : g_req
      // disabled channel never requests; source goes to cpu or dtc instead
      assign ch_request[c] = ch_armed[c] &&
        src_pending[ch_select[c*SEL_W +: SEL_W]];
    end
  endgenerate
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irq_route_pkg::*;
  logic clk, rst, hsel, hwrite, hold, fire, zero, hreadyout, hresp;
  logic dtc_request, cpu_request, dtc_done, dtc_count_zero;
  logic [11:0] haddr;
  htrans_type htrans;
  logic [2:0] hsize, cpu_request_level;
  word_type hwdata, hrdata, rd;
  logic [3:0] fire_src, dtc_request_src, cpu_request_src, dtc_done_src, dma_request, dma_done;
  logic [15:0] src_event, src_special, engine_reg_access, src_flag;
  logic [11:0] blank [5] = '{12'h000, 12'h004, 12'h008, 12'h040, 12'h100};
  int err_count, check_count, cycles;
  interrupt_source_routing dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_event(src_event),
    .src_special(src_special), .dma_done(dma_done), .dtc_done(dtc_done),
    .dtc_done_src(dtc_done_src), .dtc_count_zero(dtc_count_zero),
    .engine_reg_access(engine_reg_access), .src_flag(src_flag), .dma_request(dma_request),
    .dtc_request(dtc_request), .dtc_request_src(dtc_request_src), .cpu_request(cpu_request),
    .cpu_request_src(cpu_request_src), .cpu_request_level(cpu_request_level));
  far_side far (.clk(clk), .rst(rst), .hold(hold), .fire(fire), .fire_src(fire_src),
    .zero(zero), .dma_request(dma_request), .dtc_request(dtc_request),
    .dtc_request_src(dtc_request_src), .src_event(src_event), .dma_done(dma_done),
    .dtc_done(dtc_done), .dtc_done_src(dtc_done_src), .dtc_count_zero(dtc_count_zero));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // read data is taken at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [11:0] a, input word_type d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [11:0] a, input word_type exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] s);
    @(posedge clk);
    fire <= 1'b1;
    fire_src <= s;
    @(posedge clk);
    fire <= 1'b0;
    settle();
  endtask
  task automatic clr;
    bus(1'b1, 12'h018, 32'h0000_FFFF);
    settle();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {hsel, hwrite, fire, zero, haddr, htrans, fire_src} = '0;
    {hwdata, src_special, engine_reg_access} = '0;
    hsize = 3'h2;
    hold = 1'b1;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (blank[i]) rdchk(blank[i], 32'h0000_0000);
    bus(1'b1, 12'h040, 32'h0000_0D07);
    rdchk(12'h040, 32'h0000_0D07);
    pulse(4'h2);
    chk(cpu_request, 1'b1);
    chk(cpu_request_src, 4'h2);
    chk(dma_request, 4'h0);
    rdchk(12'h00C, 32'h0000_0004);
    clr();
    chk(src_flag, 16'h0000);
    bus(1'b1, 12'h000, 32'h0000_0020);
    pulse(4'h5);
    chk(dtc_request, 1'b1);
    chk(dtc_request_src, 4'h5);
    chk(cpu_request, 1'b0);
    hold <= 1'b0;
    settle();
    chk(src_flag, 16'h0000);
    chk(cpu_request, 1'b0);
    rdchk(12'h000, 32'h0000_0020);
    hold <= 1'b1;
    bus(1'b1, 12'h004, 32'h0000_0020);
    pulse(4'h5);
    chk(dtc_request, 1'b1);
    hold <= 1'b0;
    settle();
    rdchk(12'h000, 32'h0000_0000);
    chk(cpu_request, 1'b1);
    chk(cpu_request_src, 4'h5);
    chk(src_flag, 16'h0020);
    clr();
    hold <= 1'b1;
    zero <= 1'b1;
    bus(1'b1, 12'h004, 32'h0000_0000);
    bus(1'b1, 12'h000, 32'h0000_0020);
    pulse(4'h5);
    hold <= 1'b0;
    settle();
    rdchk(12'h000, 32'h0000_0000);
    chk(cpu_request, 1'b1);
    chk(src_flag, 16'h0000);
    clr();
    chk(cpu_request, 1'b0);
    zero <= 1'b0;
    hold <= 1'b1;
    bus(1'b1, 12'h040, 32'h0000_0000);
    bus(1'b1, 12'h000, 32'h0000_0080);
    bus(1'b1, 12'h044, 32'h0000_0D07);
    pulse(4'h7);
    chk(dma_request, 4'h2);
    chk(dtc_request, 1'b0);
    chk(cpu_request, 1'b0);
    hold <= 1'b0;
    settle();
    chk(src_flag, 16'h0000);
    hold <= 1'b1;
    bus(1'b1, 12'h000, 32'h0000_0000);
    bus(1'b1, 12'h044, 32'h0000_0507);
    pulse(4'h7);
    chk(dma_request, 4'h2);
    chk(cpu_request, 1'b1);
    hold <= 1'b0;
    settle();
    chk(src_flag, 16'h0080);
    clr();
    hold <= 1'b1;
    bus(1'b1, 12'h044, 32'h0000_0C07);
    pulse(4'h7);
    chk(dma_request, 4'h0);
    chk(cpu_request, 1'b1);
    clr();
    src_special <= 16'h0008;
    bus(1'b1, 12'h000, 32'h0000_0008);
    pulse(4'h3);
    chk(src_flag, 16'h0008);
    chk(dtc_request, 1'b1);
    engine_reg_access <= 16'h0008;
    @(posedge clk);
    engine_reg_access <= 16'h0000;
    settle();
    chk(src_flag, 16'h0000);
    bus(1'b1, 12'h000, 32'h0000_0000);
    pulse(4'h3);
    engine_reg_access <= 16'h0008;
    @(posedge clk);
    engine_reg_access <= 16'h0000;
    settle();
    chk(src_flag, 16'h0008);
    clr();
    bus(1'b1, 12'h084, 32'h0000_0002);
    bus(1'b1, 12'h090, 32'h0000_0005);
    pulse(4'h1);
    pulse(4'h4);
    chk(cpu_request_src, 4'h1);
    chk(cpu_request_level, 3'h0);
    bus(1'b1, 12'h008, 32'h0000_0008);
    settle();
    chk(cpu_request_src, 4'h4);
    chk(cpu_request_level, 3'h5);
    clr();
    test_done();
  end
endmodule
`default_nettype wire
